//--- cslp_pkg.sv
// package: register map, fields and timing counts of the can sleep-mode controller
package cslp_pkg;
   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] TXE_OFS = 8'h08;
   localparam logic [7:0] RXD_OFS = 8'h0c;
   localparam logic [7:0] RXFULL_OFS = 8'h10;
   // ==========================================================
   // field positions
   localparam int SLEEPREQ_BIT = 0;
   localparam int SLPAK_BIT = 0;
   localparam int ACTIVE_BIT = 1;
   localparam int BUSOFF_BIT = 2;
   localparam int RXFULL_BIT = 0;
   localparam int TXCNT_LSB = 8;
   // ==========================================================
   // sizes and timing
   localparam int NUM_TXBUF = 3;
   localparam logic [2:0] TXE_RESET = 3'h7;
   localparam int SYNC_NS = 12;
   localparam int CLK_NS = 4;
   localparam int SYNC_CYC = (SYNC_NS + CLK_NS - 1) / CLK_NS;
   localparam int BOFF_SEQ = 128;
   localparam int BOFF_BITS = 11;
   localparam int FRAME_BITS = 16;
   localparam int BIT_CYC = 8;
   typedef enum logic [1:0] {CSLP_RUN, CSLP_DRAIN, CSLP_SYNC, CSLP_SLEEP} cslp_state_t;
endpackage

//--- cslp_proto.sv
// protocol engine stand-in: bit timing, frame shifter, bus-off recovery count
`timescale 1ns/1ps
module cslp_proto
   import cslp_pkg::*;
#(
   parameter int BIT_CYCLES = BIT_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic protoClkEn,
   input wire logic rxPin,
   input wire logic txStart,
   input wire logic [7:0] txByte,
   input wire logic busOffIn,
   output logic txBit,
   output logic txBusy,
   output logic rxBusy,
   output logic rxDone,
   output logic [7:0] rxByte,
   output logic busOff
);
   logic [7:0] bitCnt;
   logic bitTick;
   logic [4:0] txLeft;
   logic [15:0] txShift;
   logic [4:0] rxLeft;
   logic [15:0] rxShift;
   logic [3:0] recBits;
   logic [7:0] recSeq;

   assign bitTick = protoClkEn && (bitCnt == 8'(BIT_CYCLES - 1));
   assign txBusy = txLeft != 5'h0;
   assign rxBusy = rxLeft != 5'h0;
   assign txBit = txBusy ? txShift[15] : 1'b1;

   // gated protocol clock: only bus-off entry on busOffIn moves below while protoClkEn is low
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bitCnt <= 8'h0;
      end else if (protoClkEn) begin
         bitCnt <= bitTick ? 8'h0 : bitCnt + 8'h1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         txLeft <= 5'h0;
         txShift <= 16'hffff;
      end else if (txStart && !txBusy && protoClkEn) begin
         txLeft <= 5'(FRAME_BITS);
         txShift <= {8'h00, txByte};
      end else if (bitTick && txBusy) begin
         txLeft <= txLeft - 5'h1;
         txShift <= {txShift[14:0], 1'b1};
      end
   end

   // dominant start bit opens a received frame
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rxLeft <= 5'h0;
         rxShift <= 16'h0;
         rxDone <= 1'b0;
      end else begin
         rxDone <= 1'b0;
         if (bitTick) begin
            if (!rxBusy && !txBusy && !rxPin) begin
               rxLeft <= 5'(FRAME_BITS - 1);
            end else if (rxBusy) begin
               rxShift <= {rxShift[14:0], rxPin};
               rxLeft <= rxLeft - 5'h1;
               rxDone <= rxLeft == 5'h1;
            end
         end
      end
   end
   assign rxByte = rxShift[7:0];

   // 128 runs of 11 recessive bits; count frozen with the clocks
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         busOff <= 1'b0;
         recBits <= 4'h0;
         recSeq <= 8'h0;
      end else if (busOffIn && !busOff) begin
         busOff <= 1'b1;
         recBits <= 4'h0;
         recSeq <= 8'h0;
      end else if (busOff && bitTick) begin
         if (!rxPin) begin
            recBits <= 4'h0;
         end else if (recBits == 4'(BOFF_BITS - 1)) begin
            recBits <= 4'h0;
            recSeq <= recSeq + 8'h1;
            busOff <= recSeq != 8'(BOFF_SEQ - 1);
         end else begin
            recBits <= recBits + 4'h1;
         end
      end
   end
endmodule // cslp_proto

//--- cslp_ctrl.sv
// top: ahb-lite register slave and sleep-mode sequencer of the can controller
`timescale 1ns/1ps
module cslp_ctrl
   import cslp_pkg::*;
#(
   parameter int BIT_CYCLES = cslp_pkg::BIT_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic canRxPin,
   input wire logic busOffIn,
   output logic canTransmitPin,
   output logic sleepAcknowledge
);
   import cslp_pkg::*;

   // ==========================================================
   // state
   cslp_state_t state;
   cslp_state_t next_state;
   logic sleepRequest;
   logic [NUM_TXBUF-1:0] txBufferEmptyFlags;
   logic [NUM_TXBUF-1:0] abortReq;
   logic [7:0] txData [NUM_TXBUF];
   logic [7:0] rxForegroundBuffer;
   logic rxFrameFull;
   logic [3:0] syncCnt;
   logic txInFlight;
   logic [1:0] txSel;
   logic [1:0] txPick;
   logic busOffSeen;

   // ==========================================================
   // bus slave: address phase capture
   logic wrPend;
   logic [7:0] wrAddr;
   logic addrPhase;
   logic rdEn;
   logic wrCtrl;
   logic wrTxe;
   logic wrRxFull;
   logic wrTxd;
   logic [1:0] wrTxIdx;
   logic [31:0] next_hrdata;

   assign addrPhase = hsel && hready && htrans[1];
   assign rdEn = addrPhase && !hwrite;
   assign wrCtrl = wrPend && wrAddr == CTRL_OFS;
   assign wrTxe = wrPend && wrAddr == TXE_OFS;
   assign wrRxFull = wrPend && wrAddr == RXFULL_OFS;
   assign wrTxd = wrPend && wrAddr[7:4] == 4'h2 && wrAddr[3:2] != 2'h3;
   assign wrTxIdx = wrAddr[3:2];

   // zero-wait-state slave; unmapped reads give zero, writes are dropped
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wrPend <= 1'b0;
         wrAddr <= 8'h0;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wrPend <= addrPhase && hwrite && hsize == 3'h2;
         wrAddr <= haddr;
         if (rdEn) begin
            hrdata <= next_hrdata;
         end
      end
   end

   // ==========================================================
   // protocol engine
   logic protoClkEn;
   logic txBit;
   logic txBusy;
   logic rxBusy;
   logic rxDone;
   logic [7:0] rxByte;
   logic busOff;
   logic txStart;
   logic asleep;

   assign asleep = state == CSLP_SLEEP;
   assign protoClkEn = !asleep;

   cslp_proto #(
      .BIT_CYCLES(BIT_CYCLES)
   ) uProto (
      .clk(clk),
      .rstn(rstn),
      .protoClkEn(protoClkEn),
      .rxPin(canRxPin),
      .txStart(txStart),
      .txByte(txData[txPick]),
      .busOffIn(busOffIn),
      .txBit(txBit),
      .txBusy(txBusy),
      .rxBusy(rxBusy),
      .rxDone(rxDone),
      .rxByte(rxByte),
      .busOff(busOff)
   );

   // lowest pending buffer wins
   function automatic logic [1:0] firstPending(input logic [NUM_TXBUF-1:0] e);
      logic [1:0] idx;
      idx = 2'h0;
      for (int i = NUM_TXBUF - 1; i >= 0; i--) begin
         if (!e[i]) begin
            idx = 2'(i);
         end
      end
      return idx;
   endfunction

   // a buffer whose abort waits is never started: the abort empties it first
   logic [NUM_TXBUF-1:0] txHeld;
   logic anyPending;
   assign txHeld = txBufferEmptyFlags | abortReq;
   assign txPick = firstPending(txHeld);
   assign anyPending = txBufferEmptyFlags != {NUM_TXBUF{1'b1}};
   assign txStart = txHeld != {NUM_TXBUF{1'b1}} && !txInFlight && !rxBusy && !asleep;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         txInFlight <= 1'b0;
         txSel <= 2'h0;
         busOffSeen <= 1'b0;
      end else begin
         busOffSeen <= busOff;
         if (txStart) begin
            txInFlight <= 1'b1;
            txSel <= txPick;
         end else if (txInFlight && !txBusy && protoClkEn && !txStart) begin
            txInFlight <= txBusy;
         end
      end
   end

   // ==========================================================
   // transmit buffers and empty flags
   logic txDoneEv;
   assign txDoneEv = txInFlight && !txBusy && !txStart && protoClkEn;

   always_ff @(posedge clk) begin
      // buffer writes work in any state
      if (wrTxd) begin
         txData[wrTxIdx] <= hwdata[7:0];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         txBufferEmptyFlags <= TXE_RESET;
         abortReq <= '0;
      end else begin
         // writing one clears an empty flag (schedules); allowed while asleep
         if (wrTxe) begin
            txBufferEmptyFlags <= txBufferEmptyFlags & ~hwdata[NUM_TXBUF-1:0];
            abortReq <= abortReq | hwdata[NUM_TXBUF+7:8];
         end
         if (txDoneEv) begin
            txBufferEmptyFlags[txSel] <= 1'b1;
         end
         // aborts only taken while awake, idle buffers only
         if (!asleep) begin
            for (int i = 0; i < NUM_TXBUF; i++) begin
               if (abortReq[i] && !(txInFlight && txSel == 2'(i))) begin
                  txBufferEmptyFlags[i] <= 1'b1;
                  abortReq[i] <= 1'b0;
               end
            end
         end
      end
   end

   // ==========================================================
   // receive foreground buffer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rxFrameFull <= 1'b0;
         rxForegroundBuffer <= 8'h0;
      end else begin
         // loading only while awake; set beats clear
         if (rxDone && !asleep && !rxFrameFull) begin
            rxFrameFull <= 1'b1;
            rxForegroundBuffer <= rxByte;
         end else if (wrRxFull && hwdata[RXFULL_BIT]) begin
            rxFrameFull <= 1'b0;
         end
      end
   end

   // ==========================================================
   // sleep sequencer
   always_comb begin
      next_state = state;
      unique case (state)
         CSLP_RUN: begin
            if (sleepRequest) begin
               next_state = CSLP_DRAIN;
            end
         end
         CSLP_DRAIN: begin
            if (!sleepRequest) begin
               next_state = CSLP_RUN;
            // wait for tx drain and bus idle
            end else if (!anyPending && !txInFlight && !rxBusy) begin
               next_state = CSLP_SYNC;
            end
         end
         CSLP_SYNC: begin
            if (!sleepRequest) begin
               next_state = CSLP_RUN;
            end else if (syncCnt == 4'(SYNC_CYC - 1)) begin
               next_state = CSLP_SLEEP;
            end
         end
         CSLP_SLEEP: begin
            if (!sleepRequest) begin
               next_state = CSLP_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= CSLP_RUN;
         syncCnt <= 4'h0;
         sleepRequest <= 1'b0;
         sleepAcknowledge <= 1'b0;
         canTransmitPin <= 1'b1;
      end else begin
         state <= next_state;
         syncCnt <= (state == CSLP_SYNC) ? syncCnt + 4'h1 : 4'h0;
         if (wrCtrl) begin
            sleepRequest <= hwdata[SLEEPREQ_BIT];
         end
         sleepAcknowledge <= next_state == CSLP_SLEEP;
         canTransmitPin <= (next_state == CSLP_SLEEP) ? 1'b1 : txBit;
      end
   end

   // ==========================================================
   // read mux
   always_comb begin
      next_hrdata = 32'h0;
      unique case (haddr)
         CTRL_OFS: next_hrdata[SLEEPREQ_BIT] = sleepRequest;
         STAT_OFS: begin
            next_hrdata[SLPAK_BIT] = sleepAcknowledge;
            next_hrdata[ACTIVE_BIT] = txInFlight || rxBusy;
            next_hrdata[BUSOFF_BIT] = busOffSeen;
         end
         TXE_OFS: begin
            next_hrdata[NUM_TXBUF-1:0] = txBufferEmptyFlags;
            next_hrdata[NUM_TXBUF+7:TXCNT_LSB] = abortReq;
         end
         RXD_OFS: next_hrdata[7:0] = rxForegroundBuffer;
         RXFULL_OFS: next_hrdata[RXFULL_BIT] = rxFrameFull;
         default: next_hrdata = 32'h0;
      endcase
   end
endmodule // cslp_ctrl

//--- cslp_ctrl_checker.sv
// checker: sleep handshake properties seen at the controller ports
`timescale 1ns/1ps
module cslp_ctrl_checker
   import cslp_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic canRxPin,
   input wire logic canTransmitPin,
   input wire logic sleepAcknowledge
);
   logic ctrlWr;
   logic reqShadow;
   // ==========================================================
   // shadow of the request bit, rebuilt from bus writes only
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrlWr <= 1'b0;
         reqShadow <= 1'b0;
      end else begin
         ctrlWr <= hsel && hready && htrans[1] && hwrite && hsize == 3'h2 && haddr == CTRL_OFS;
         if (ctrlWr) begin
            reqShadow <= hwdata[SLEEPREQ_BIT];
         end
      end
   end
   // ==========================================================
   // properties
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   sequence s_reqRise;
      $rose(reqShadow);
   endsequence
   sequence s_stayAwake;
      !sleepAcknowledge [*3];
   endsequence
   a_sync_delay: assert property (s_reqRise |-> s_stayAwake)
      else $error("sleep entered before the sync delay");
   a_entry_bounded: assert property (s_reqRise |-> ##[1:600] (sleepAcknowledge || !reqShadow))
      else $error("sleep never entered");
   a_ack_needs_req: assert property (sleepAcknowledge |-> reqShadow || $past(reqShadow))
      else $error("acknowledge without request");
   a_wake_prompt: assert property ($fell(reqShadow) |-> ##1 !sleepAcknowledge)
      else $error("acknowledge held after request cleared");
   a_stay_asleep: assert property (sleepAcknowledge && reqShadow |=> sleepAcknowledge)
      else $error("sleep left while requested");
   a_pin_recessive: assert property (sleepAcknowledge |-> canTransmitPin)
      else $error("transmit pin dominant in sleep");
   a_rx_idle_entry: assert property ($rose(sleepAcknowledge) |-> $past(canRxPin) && $past(canRxPin, 2))
      else $error("sleep entered with receive line busy");
   a_tx_quiet_entry: assert property ($rose(sleepAcknowledge) |-> $past(canTransmitPin) && $past(canTransmitPin, 2))
      else $error("sleep entered during transmission");
   a_regs_alive: assert property (sleepAcknowledge |-> hreadyout && !hresp)
      else $error("register bus stalled in sleep");
endmodule // cslp_ctrl_checker

bind cslp_ctrl cslp_ctrl_checker chk (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
   .hreadyout, .hresp, .canRxPin, .canTransmitPin, .sleepAcknowledge);

//--- cslp_can_node.sv
// partner: remote can node sending frames on the receive line
`timescale 1ns/1ps
module cslp_can_node #(
   parameter int BIT_CYCLES = 2
) (
   input wire logic clk,
   input wire logic go,
   input wire logic [7:0] frameByte,
   output logic busLine,
   output logic busy
);
   logic [15:0] frame;
   // bus idles recessive; frame is 8 dominant bits then the byte msb first
   initial begin
      busLine = 1'b1;
      busy = 1'b0;
      forever begin
         @(posedge clk);
         if (go) begin
            busy <= 1'b1;
            frame = {8'h00, frameByte};
            for (int i = 15; i >= 0; i--) begin
               busLine <= frame[i];
               repeat (BIT_CYCLES) @(posedge clk);
            end
            busLine <= 1'b1;
            busy <= 1'b0;
         end
      end
   end
endmodule // cslp_can_node

//--- cslp_tb.sv
// testbench: sleep sequences of the can controller against a bench model
`timescale 1ns/1ps
module testbench;
   import cslp_pkg::*;
   localparam int BITC = 2;
   // recovery needs 128 x 11 recessive bits, plus margin
   localparam int BOFF_WAIT = BOFF_SEQ * BOFF_BITS * BITC + 200;
   logic clk, rstn, hsel, hwrite, canRxPin, busOffIn, go, nodeBusy;
   logic hreadyout, hresp, canTransmitPin, sleepAcknowledge;
   logic [7:0] haddr, frameByte, b;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd;
   wire logic hready = hreadyout;
   int errTotal = 0;
   int nCompared = 0;
   int cyc = 0;
   int mTxe, mRxFull;
   logic [7:0] rxq[$];
   logic [7:0] txq[$];
   logic [15:0] txFrame;
   logic [31:0] d;
   cslp_ctrl #(.BIT_CYCLES(BITC)) uut (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hrdata, .hreadyout, .hresp, .canRxPin, .busOffIn, .canTransmitPin, .sleepAcknowledge);
   cslp_can_node #(.BIT_CYCLES(BITC)) node (.clk, .go, .frameByte, .busLine(canRxPin), .busy(nodeBusy));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // watcher on the transmit pin: 8 dominant bits, then the byte msb first
   initial begin
      forever begin
         @(posedge clk);
         if (rstn === 1'b1 && canTransmitPin === 1'b0) begin
            txFrame = 16'h0;
            for (int k = 1; k < 16; k++) begin
               repeat (BITC) @(posedge clk);
               txFrame = {txFrame[14:0], canTransmitPin};
            end
            if (txq.size() == 0) begin
               chkw("txUnexpected", 32'h0, 32'h1);
            end else begin
               chkw("txFrame", {24'h0, txq.pop_front()}, {16'h0, txFrame});
            end
            // a last dominant bit must not be taken for a new start
            while (canTransmitPin !== 1'b1) @(posedge clk);
         end
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errTotal++;
         wrapUp();
      end
   end
   // ==========================================================
   // compare, bus and stimulus tasks
   task automatic chkw(input string nm, input logic [31:0] e, input logic [31:0] g);
      nCompared++;
      if (g !== e) begin
         errTotal++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chkb(input string nm, input logic e, input logic g);
      chkw(nm, {31'h0, e}, {31'h0, g});
   endtask
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [2:0] sz);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      hsize <= sz;
      htrans <= 2'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d, 3'h2);
   endtask
   task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0, 3'h2);
      chkw(nm, e & m, rd & m);
   endtask
   // software polls instead of assuming the state changed
   task automatic poll(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      int n;
      n = 0;
      do begin
         xfer(a, 1'b0, 32'h0, 3'h2);
         n++;
      end while ((rd & m) !== (e & m) && n < 300);
      chkw(nm, e & m, rd & m);
   endtask
   task automatic sendFrame(input logic [7:0] v, input logic waitDone);
      frameByte <= v;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      if (waitDone) begin
         @(posedge clk);
         while (nodeBusy) @(posedge clk);
      end
   endtask
   task automatic wrapUp();
      if (errTotal == 0 && nCompared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(32'hd14a));
      rstn = 1'b0;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      busOffIn = 1'b0;
      go = 1'b0;
      frameByte = 8'h00;
      mTxe = int'(TXE_RESET);
      mRxFull = 0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      chkb("pinReset", 1'b1, canTransmitPin);
      rdChk("txeReset", TXE_OFS, 32'h7, 32'(mTxe));
      wr(8'h40, 32'hffff_ffff);
      rdChk("unmapped", 8'h40, 32'hffff_ffff, 32'h0);
      xfer(CTRL_OFS, 1'b1, 32'h1, 3'h0);
      rdChk("narrowWrite", CTRL_OFS, 32'h1, 32'h0);
      wr(CTRL_OFS, 32'h1);
      poll("idleAck", STAT_OFS, 32'h1, 32'h1);
      rdChk("reqInSleep", CTRL_OFS, 32'h1, 32'h1);
      wr(TXE_OFS, 32'h1);
      wr(TXE_OFS, 32'h100);
      mTxe = 6;
      rdChk("txeSleep", TXE_OFS, 32'h7, 32'(mTxe));
      wr(CTRL_OFS, 32'h0);
      poll("wakeAck", STAT_OFS, 32'h1, 32'h0);
      mTxe = 7;
      poll("txeWake", TXE_OFS, 32'h7, 32'(mTxe));
      for (int i = 0; i < 2; i++) begin
         d = $urandom & 32'hff;
         txq.push_back(d[7:0]);
         wr(8'h20 + 8'(4 * i), d);
      end
      wr(TXE_OFS, 32'h3);
      mTxe = 4;
      rdChk("txeQueued", TXE_OFS, 32'h7, 32'(mTxe));
      // spacing keeps the order of transmit and sleep defined
      repeat (4) @(posedge clk);
      wr(CTRL_OFS, 32'h1);
      poll("drainAck", STAT_OFS, 32'h1, 32'h1);
      mTxe = 7;
      rdChk("txeDrained", TXE_OFS, 32'h7, 32'(mTxe));
      wr(CTRL_OFS, 32'h0);
      poll("wakeAck2", STAT_OFS, 32'h1, 32'h0);
      b = 8'($urandom);
      rxq.push_back(b);
      sendFrame(b, 1'b0);
      repeat (8) @(posedge clk);
      wr(CTRL_OFS, 32'h1);
      poll("rxAck", STAT_OFS, 32'h1, 32'h1);
      chkb("rxDoneFirst", 1'b0, nodeBusy);
      mRxFull = 1;
      rdChk("rxFullSleep", RXFULL_OFS, 32'h1, 32'(mRxFull));
      rdChk("rxdSleep", RXD_OFS, 32'hff, {24'h0, rxq.pop_front()});
      wr(RXFULL_OFS, 32'h1);
      mRxFull = 0;
      rdChk("rxFullCleared", RXFULL_OFS, 32'h1, 32'(mRxFull));
      sendFrame(~b, 1'b1);
      rdChk("rxFullIgnored", RXFULL_OFS, 32'h1, 32'(mRxFull));
      wr(CTRL_OFS, 32'h0);
      poll("wakeAck3", STAT_OFS, 32'h1, 32'h0);
      busOffIn <= 1'b1;
      @(posedge clk);
      busOffIn <= 1'b0;
      wr(CTRL_OFS, 32'h1);
      poll("boffAck", STAT_OFS, 32'h1, 32'h1);
      repeat (BOFF_WAIT) @(posedge clk);
      rdChk("boffFrozen", STAT_OFS, 32'h4, 32'h4);
      wr(CTRL_OFS, 32'h0);
      repeat (BOFF_WAIT) @(posedge clk);
      rdChk("boffRecovered", STAT_OFS, 32'h5, 32'h0);
      chkw("txPending", 32'h0, 32'(txq.size()));
      wrapUp();
   end
endmodule // testbench
